/* shared/egp_pkg.sv */
package egp_pkg;

	// ==========================================================
	// Clock and time
	localparam int unsigned EGP_CLK_HZ         = 32'h017D_7840;	// 25 MHz
	localparam int unsigned EGP_SEC_S          = 32'h0000_0001;
	localparam int unsigned EGP_CYCLES_PER_SEC = EGP_SEC_S * EGP_CLK_HZ;
	localparam logic [23:0] EGP_TIME_MIN_S     = 24'h00_0001;
	// 99 d 23 h 59 min 59 s
	localparam logic [23:0] EGP_TIME_MAX_S     = 24'(99 * 86400 + 23 * 3600 + 59 * 60 + 59);

	// ==========================================================
	// Error-count periods
	localparam logic [9:0]  EGP_ERR_P10   = 10'h00A;
	localparam logic [9:0]  EGP_ERR_P100  = 10'h064;
	localparam logic [9:0]  EGP_ERR_P1000 = 10'h3E8;

	// ==========================================================
	// Pattern orders, stores, packing, sizes
	localparam logic [4:0]  EGP_ORD7      = 5'h07;
	localparam logic [4:0]  EGP_ORD10     = 5'h0A;
	localparam logic [4:0]  EGP_ORD15     = 5'h0F;
	localparam logic [4:0]  EGP_ORD23     = 5'h17;
	localparam logic [4:0]  EGP_ORD31     = 5'h1F;
	localparam logic [4:0]  EGP_STORE_MAX = 5'h0C;
	localparam logic [23:0] EGP_PACK1     = 24'h00_0001;
	localparam logic [23:0] EGP_PACK8     = 24'h00_0008;
	localparam int          EGP_PAT_BITS  = 32'h0000_0100;
	localparam logic [8:0]  EGP_HALF_BITS = 9'h080;
	localparam logic [8:0]  EGP_FULL_BITS = 9'h100;
	localparam int          EGP_BUF_WIDTH = 32'h0000_0008;
	localparam int          EGP_BUF_DEPTH = 32'h0000_0002;

	// ==========================================================
	// Reset values
	localparam logic [9:0]  EGP_RST_ERR_PERIOD = EGP_ERR_P10;
	localparam logic [23:0] EGP_RST_TIME_S     = EGP_TIME_MIN_S;
	localparam logic [8:0]  EGP_RST_LEN        = EGP_HALF_BITS;
	localparam logic [7:0]  EGP_RST_DENSITY    = 8'h80;
	localparam logic [4:0]  EGP_RST_ORDER      = EGP_ORD7;

	// ==========================================================
	// Types
	typedef enum logic [3:0] {
		EGP_CMD_GATE_ERR   = 4'h0,
		EGP_CMD_GATE_TIME  = 4'h1,
		EGP_CMD_GATE_STATE = 4'h2,
		EGP_CMD_PACKING    = 4'h3,
		EGP_CMD_DENSITY    = 4'h4,
		EGP_CMD_SELECT_ED  = 4'h5,
		EGP_CMD_SELECT_PG  = 4'h6,
		EGP_CMD_TRACK      = 4'h7,
		EGP_CMD_MODE       = 4'h8,
		EGP_CMD_LENGTH     = 4'h9,
		EGP_CMD_WRITE_FULL = 4'hA,
		EGP_CMD_WRITE_PART = 4'hB,
		EGP_CMD_READ_PART  = 4'hC
	} egp_cmd_type;

	typedef enum logic [2:0] {
		EGP_KIND_PRBS     = 3'h0,
		EGP_KIND_ALT_PRBS = 3'h1,
		EGP_KIND_ZSUB     = 3'h2,
		EGP_KIND_MDEN     = 3'h3,
		EGP_KIND_USER     = 3'h4
	} egp_kind_type;

	typedef enum logic [1:0] {
		EGP_ENG_IDLE  = 2'h0,
		EGP_ENG_WRITE = 2'h1,
		EGP_ENG_READ  = 2'h2
	} egp_eng_type;

endpackage

/* testbench/egp_ctrl_model.sv */
`timescale 1ns/10ps
// ==========
// Remote controller: commands, download, readback
module egp_ctrl_model (
	input  wire logic            sys_clk,
	output logic                 cmd_valid,
	output egp_pkg::egp_cmd_type cmd_op,
	output logic [23:0]          cmd_arg,
	output logic                 cmd_half_b,
	output logic [7:0]           cmd_start,
	output logic [8:0]           cmd_count,
	output logic [15:0]          cmd_bytes,
	input  wire logic            cmd_ack,
	input  wire logic            cmd_err,
	output logic                 dl_valid,
	output logic [7:0]           dl_byte,
	input  wire logic            dl_ready,
	input  wire logic            rd_valid,
	input  wire logic [7:0]      rd_byte,
	output logic                 rd_ready
);
	initial begin
		{cmd_valid, cmd_arg, cmd_half_b, cmd_start, cmd_count, cmd_bytes} = '0;
		{dl_valid, dl_byte, rd_ready} = '0;
		cmd_op = egp_pkg::EGP_CMD_GATE_ERR;
	end
	task automatic send(input logic [3:0] op, input logic [23:0] arg, input logic hb,
		input logic [8:0] cnt, input logic [15:0] nb, input logic [7:0] st,
		output logic [1:0] ans);
		@(posedge sys_clk);
		cmd_valid <= 1'b1;
		cmd_op <= egp_pkg::egp_cmd_type'(op);
		cmd_arg <= arg;
		cmd_half_b <= hb;
		cmd_count <= cnt;
		cmd_start <= st;
		cmd_bytes <= nb;
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		cmd_arg <= ~arg;
		#1 ans = {cmd_ack, cmd_err};
	endtask
	task automatic put(input logic [7:0] b);
		@(posedge sys_clk);
		dl_valid <= 1'b1;
		dl_byte <= b;
		do @(posedge sys_clk); while (!dl_ready);
		dl_valid <= 1'b0;
		dl_byte <= ~b;
	endtask
	// Stalls before taking the byte
	task automatic get(output logic [7:0] b);
		repeat (3) @(posedge sys_clk);
		rd_ready <= 1'b1;
		do @(posedge sys_clk); while (!rd_valid);
		b = rd_byte;
		rd_ready <= 1'b0;
	endtask
endmodule // egp_ctrl_model

/* testbench/egp_gate_pattern_tb_top.sv */
`timescale 1ns/10ps
module egp_gate_pattern_tb_top;
	logic sys_clk = 1'b0, rst_n = 1'b0, gate_by_errors = 1'b1, gate_single = 1'b1;
	logic bit_error = 1'b0, cmd_valid, cmd_half_b, cmd_ack, cmd_err, gate_on, results_valid;
	logic period_done, pack8, track_on, alt_mode, trigger_changeover, dl_valid, dl_ready;
	logic dl_bad, rd_valid, rd_ready;
	logic [23:0] cmd_arg, gate_time_period;
	logic [7:0]  cmd_start, mark_density, dl_byte, rd_byte, b;
	logic [8:0]  cmd_count, pat_length;
	logic [15:0] cmd_bytes;
	logic [9:0]  gate_err_period;
	logic [4:0]  sel_order;
	logic [3:0]  user_store;
	logic [1:0]  ans;
	egp_pkg::egp_cmd_type  cmd_op;
	egp_pkg::egp_kind_type sel_kind;
	int failures = 0, n_checks = 0, n_cycles = 0;
	typedef struct packed {logic [3:0] op; logic [23:0] arg; logic err;} egp_row_type;
	egp_row_type rows [16] = '{
		'{4'h0, 24'h00_0064, 1'b0}, '{4'h0, 24'h00_0032, 1'b1}, '{4'h1, 24'h00_0000, 1'b1},
		'{4'h1, 24'h83_D5FF, 1'b0}, '{4'h1, 24'h83_D600, 1'b1}, '{4'h3, 24'h00_0002, 1'b1},
		'{4'h3, 24'h00_0008, 1'b0}, '{4'h4, 24'h00_0033, 1'b0}, '{4'h5, 24'h00_001F, 1'b0},
		'{4'h5, 24'h00_011F, 1'b1}, '{4'h5, 24'h00_0207, 1'b1}, '{4'h5, 24'h00_040D, 1'b1},
		'{4'h5, 24'h00_040C, 1'b0}, '{4'h8, 24'h00_0001, 1'b0}, '{4'h9, 24'h00_0081, 1'b1},
		'{4'hB, 24'h00_0000, 1'b1}};
	egp_gate_pattern #(.CYCLES_PER_SEC(4)) i_egp_gate_pattern (.*);
	egp_ctrl_model i_egp_ctrl_model (.*);
	always #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		n_cycles++;
		if (n_cycles == 5000) begin
			failures++;
			summarize();
		end
	end
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic summarize();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic cmd(input logic [3:0] op, input logic [23:0] arg, input logic hb = 1'b0,
		input logic [8:0] cnt = 9'h000, input logic [15:0] nb = 16'h0000,
		input logic [7:0] st = 8'h00);
		i_egp_ctrl_model.send(op, arg, hb, cnt, nb, st, ans);
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		#1 chk("reset", {10'h00A, 24'h00_0001, 8'h80, 9'h080, 2'b00}, {gate_err_period,
			gate_time_period, mark_density, pat_length, gate_on, results_valid});
		foreach (rows[i]) begin
			cmd(rows[i].op, rows[i].arg);
			chk("answer", {!rows[i].err, rows[i].err}, ans);
		end
		chk("config", {10'h064, 24'h83_D5FF, 1'b1, 8'h33, 3'h4, 4'hC, 1'b1, 9'h080, 1'b1},
			{gate_err_period, gate_time_period, pack8, mark_density, sel_kind, user_store,
			alt_mode, pat_length, trigger_changeover});
		cmd(4'hA, 24'h00_0000, 1'b1, 9'h000, 16'h0001);
		i_egp_ctrl_model.put(8'hA5);
		repeat (10) @(posedge sys_clk);
		#1 chk("length", 9'h008, pat_length);
		cmd(4'hC, 24'h00_0000, 1'b1, 9'h008);
		i_egp_ctrl_model.get(b);
		chk("readback", 8'hA5, b);
		cmd(4'h8, 24'h00_0000);
		cmd(4'hB, 24'h00_0000, 1'b1, 9'h001, 16'h0001);
		chk("half_b", 2'b01, ans);
		cmd(4'hA, 24'h00_0000, 1'b1, 9'h000, 16'h0001);
		chk("half_b_full", 2'b01, ans);
		cmd(4'h3, 24'h00_0001);
		cmd(4'hB, 24'h00_0000, 1'b0, 9'h002, 16'h0002, 8'h03);
		i_egp_ctrl_model.put(8'h01);
		i_egp_ctrl_model.put(8'h02);
		@(posedge sys_clk);
		#1 chk("dl_bad", 1'b1, dl_bad);
		cmd(4'hC, 24'h00_0000, 1'b0, 9'h002, 16'h0000, 8'h03);
		i_egp_ctrl_model.get(b);
		chk("pack1_rd0", 8'h01, b);
		i_egp_ctrl_model.get(b);
		chk("pack1_rd1", 8'h00, b);
		cmd(4'h6, 24'h00_000A);
		cmd(4'h7, 24'h00_0001);
		cmd(4'h6, 24'h00_030F);
		chk("track", {1'b1, 3'h3, 5'h0F}, {track_on, sel_kind, sel_order});
		cmd(4'h0, 24'h00_000A);
		repeat (4) @(posedge sys_clk);
		cmd(4'h2, 24'h00_0001);
		chk("gate_on", 1'b1, gate_on);
		@(posedge sys_clk);
		bit_error <= 1'b1;
		repeat (10) @(posedge sys_clk);
		bit_error <= 1'b0;
		repeat (3) @(posedge sys_clk);
		#1 chk("period", 2'b10, {results_valid, gate_on});
		cmd(4'h0, 24'h00_03E8);
		chk("invalid", 1'b0, results_valid);
		@(posedge sys_clk);
		{gate_by_errors, gate_single, bit_error} <= 3'b001;
		cmd(4'h1, 24'h00_0001);
		cmd(4'h2, 24'h00_0001);
		repeat (8) @(posedge sys_clk);
		#1 chk("time_gate", 3'b111, {results_valid, gate_on, period_done});
		summarize();
	end
endmodule // egp_gate_pattern_tb_top

/* verilog/egp_buffer.sv */
`timescale 1ns/10ps
module egp_buffer #(
	parameter int WIDTH = egp_pkg::EGP_BUF_WIDTH,
	parameter int DEPTH = egp_pkg::EGP_BUF_DEPTH
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_idx;
	logic [AW:0]      cnt_reg;
	logic [AW:0]      cnt_next;
	logic             push;
	logic             pop;

	assign push     = in_valid && in_ready;
	assign pop      = out_valid && out_ready;
	// Head kept in entry 0, so the output is a plain flop
	assign out_data = mem_reg[0];
	assign wr_idx   = AW'(cnt_reg - (AW + 1)'(pop));
	assign cnt_next = cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);

	// ==========================================================
	// Storage and pointers
	always_ff @(posedge sys_clk) begin
		if (pop) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				mem_reg[i] <= mem_reg[i + 1];
			end
		end
		if (push) begin
			mem_reg[wr_idx] <= in_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cnt_reg   <= '0;
			in_ready  <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			cnt_reg   <= cnt_next;
			in_ready  <= cnt_next != (AW + 1)'(DEPTH);
			out_valid <= cnt_next != '0;
		end
	end

endmodule // egp_buffer

/* verilog/egp_gate_pattern.sv */
`timescale 1ns/10ps
// Function
// [R1] Error-count period is 10, 100 or 1000
// [R2] Time period from 1 s to 99d23h59m59s
// [R3] Error period used only in error manner
// [R4] Period write invalidates past results; a period end (hit) in the same cycle still sets results_valid
// [R5] Gate state starts/stops accumulation, readable
// [R6] Controller settles frequency, syncs before gate on
// [R7] Single-mode gate runs while commands accepted
// [R8] Packing 1 or 8 bits; 1-bit bytes 0/1
// [R9] 8-bit packing: first byte MSB is bit 0
// [R10] Mark density held and readable
// [R11] Orders 7..31 for PRBS; 7..23 others
// [R12] Zero substitution selection is refused
// [R13] Store 0 current, 1 to 12 disk
// [R14] User selection reads back type only
// [R15] Coupled generator select also sets detector
// [R16] Tracking couples detector to generator, readable
// [R17] Half B only in alternate mode
// [R18] Download length always counts bytes
// [R19] Full write sets length to bits written
// [R20] Partial write/read covers start and count
// [R21] Whole or alternate mode, readable
// [R22] User pattern length writable and readable
// [R23] Partial start counts first bit as zero
// [R24] Alternate entry: 128 bits/half, cleared, trigger
// [R25] Alternate length applies to each half
// [R26] Out-of-range settings refused, value kept
module egp_gate_pattern #(
	parameter int unsigned CYCLES_PER_SEC = egp_pkg::EGP_CYCLES_PER_SEC
) (
	input  wire logic                     sys_clk,
	input  wire logic                     rst_n,
	input  wire logic                     cmd_valid,
	input  egp_pkg::egp_cmd_type          cmd_op,
	input  wire logic [23:0]              cmd_arg,
	input  wire logic                     cmd_half_b,
	input  wire logic [7:0]               cmd_start,
	input  wire logic [8:0]               cmd_count,
	input  wire logic [15:0]              cmd_bytes,
	output logic                          cmd_ack,
	output logic                          cmd_err,
	input  wire logic                     gate_by_errors,
	input  wire logic                     gate_single,
	input  wire logic                     bit_error,
	output logic                          gate_on,
	output logic                          results_valid,
	output logic                          period_done,
	output logic [9:0]                    gate_err_period,
	output logic [23:0]                   gate_time_period,
	output logic                          pack8,
	output logic [7:0]                    mark_density,
	output egp_pkg::egp_kind_type         sel_kind,
	output logic [4:0]                    sel_order,
	output logic [3:0]                    user_store,
	output logic                          track_on,
	output logic                          alt_mode,
	output logic [8:0]                    pat_length,
	output logic                          trigger_changeover,
	input  wire logic                     dl_valid,
	input  wire logic [7:0]               dl_byte,
	output logic                          dl_ready,
	output logic                          dl_bad,
	output logic                          rd_valid,
	output logic [7:0]                    rd_byte,
	input  wire logic                     rd_ready
);
	logic                          cmd_ok;
	logic                          gate_cmd;
	logic                          period_wr;
	logic                          hit;
	logic                          tick_end;
	logic [9:0]                    err_cnt_reg;
	logic [23:0]                   sec_cnt_reg;
	logic [24:0]                   tick_cnt_reg;
	egp_pkg::egp_kind_type         arg_kind;
	logic [4:0]                    arg_n;
	logic [8:0]                    half_base;
	egp_pkg::egp_eng_type          eng_reg;
	logic [egp_pkg::EGP_PAT_BITS-1:0] pat_reg;
	logic [8:0]                    pos_reg;
	logic [8:0]                    remain_reg;
	logic [8:0]                    base_reg;
	logic [15:0]                   bytes_left_reg;
	logic [7:0]                    byte_reg;
	logic [2:0]                    bit_idx_reg;
	logic                          holding_reg;
	logic                          full_reg;
	logic [7:0]                    bit_addr;
	logic                          unit_bit;
	logic                          unit_good;
	logic                          unit_last;
	logic [8:0]                    pos_after;
	logic [7:0]                    rd_acc_reg;
	logic [3:0]                    rd_n_reg;
	logic                          push_reg;
	logic                          buf_in_ready;
	logic                          rd_bit;
	logic                          rd_last;
	logic [7:0]                    rd_done;

	// ==========================================================
	// Helpers
	function automatic logic order_ok(input egp_pkg::egp_kind_type k, input logic [4:0] n);
		logic base_set;
		base_set = (n == egp_pkg::EGP_ORD7) || (n == egp_pkg::EGP_ORD10) ||
			(n == egp_pkg::EGP_ORD15) || (n == egp_pkg::EGP_ORD23);
		case (k)
			egp_pkg::EGP_KIND_PRBS: return base_set || (n == egp_pkg::EGP_ORD31);
			egp_pkg::EGP_KIND_ALT_PRBS, egp_pkg::EGP_KIND_MDEN: return base_set;
			egp_pkg::EGP_KIND_USER: return n <= egp_pkg::EGP_STORE_MAX;
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic [8:0] cap_of(input logic alt);
		return alt ? egp_pkg::EGP_HALF_BITS : egp_pkg::EGP_FULL_BITS;
	endfunction

	function automatic logic fit_ok(input logic [7:0] s, input logic [8:0] c, input logic alt);
		return (c != 9'h000) && (({2'b00, s} + {1'b0, c}) <= {1'b0, cap_of(alt)});
	endfunction

	// ==========================================================
	// Command decode
	assign arg_kind  = egp_pkg::egp_kind_type'(cmd_arg[10:8]);
	assign arg_n     = cmd_arg[4:0];
	assign half_base = (alt_mode && cmd_half_b) ? egp_pkg::EGP_HALF_BITS : 9'h000;
	assign gate_cmd  = cmd_valid && cmd_ok && (cmd_op == egp_pkg::EGP_CMD_GATE_STATE);
	assign period_wr = cmd_valid && cmd_ok &&
		(cmd_op == egp_pkg::EGP_CMD_GATE_ERR || cmd_op == egp_pkg::EGP_CMD_GATE_TIME);

	always_comb begin
		cmd_ok = 1'b0;
		case (cmd_op)
			egp_pkg::EGP_CMD_GATE_ERR: cmd_ok = (cmd_arg[23:10] == 14'h0000) &&	// R1
				(cmd_arg[9:0] == egp_pkg::EGP_ERR_P10 || cmd_arg[9:0] == egp_pkg::EGP_ERR_P100 ||
				cmd_arg[9:0] == egp_pkg::EGP_ERR_P1000);
			egp_pkg::EGP_CMD_GATE_TIME: cmd_ok = cmd_arg >= egp_pkg::EGP_TIME_MIN_S &&
				cmd_arg <= egp_pkg::EGP_TIME_MAX_S;	// R2
			egp_pkg::EGP_CMD_GATE_STATE, egp_pkg::EGP_CMD_DENSITY,
			egp_pkg::EGP_CMD_TRACK: cmd_ok = 1'b1;
			egp_pkg::EGP_CMD_PACKING: cmd_ok = (eng_reg == egp_pkg::EGP_ENG_IDLE) &&
				(cmd_arg == egp_pkg::EGP_PACK1 || cmd_arg == egp_pkg::EGP_PACK8);	// R8
			egp_pkg::EGP_CMD_SELECT_ED,
			egp_pkg::EGP_CMD_SELECT_PG: cmd_ok = order_ok(arg_kind, arg_n);	// R11 R12 R13
			egp_pkg::EGP_CMD_MODE: cmd_ok = eng_reg == egp_pkg::EGP_ENG_IDLE;
			egp_pkg::EGP_CMD_LENGTH: cmd_ok = (eng_reg == egp_pkg::EGP_ENG_IDLE) &&
				cmd_arg >= 24'h00_0001 && cmd_arg <= {15'h0000, cap_of(alt_mode)};	// R22 R25
			egp_pkg::EGP_CMD_WRITE_FULL: cmd_ok = (eng_reg == egp_pkg::EGP_ENG_IDLE) &&
				(!cmd_half_b || alt_mode);	// R17
			egp_pkg::EGP_CMD_WRITE_PART,
			egp_pkg::EGP_CMD_READ_PART: cmd_ok = (eng_reg == egp_pkg::EGP_ENG_IDLE) &&
				(!cmd_half_b || alt_mode) && fit_ok(cmd_start, cmd_count, alt_mode);	// R17 R20
			default: cmd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cmd_ack <= 1'b0;
			cmd_err <= 1'b0;
		end else begin
			cmd_ack <= cmd_valid && cmd_ok;
			cmd_err <= cmd_valid && !cmd_ok;	// R26
		end
	end

	// ==========================================================
	// Configuration
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			gate_err_period  <= egp_pkg::EGP_RST_ERR_PERIOD;
			gate_time_period <= egp_pkg::EGP_RST_TIME_S;
		end else if (cmd_valid && cmd_ok && cmd_op == egp_pkg::EGP_CMD_GATE_ERR) begin
			gate_err_period <= cmd_arg[9:0];	// R1
		end else if (cmd_valid && cmd_ok && cmd_op == egp_pkg::EGP_CMD_GATE_TIME) begin
			gate_time_period <= cmd_arg;	// R2
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sel_kind     <= egp_pkg::EGP_KIND_PRBS;
			sel_order    <= egp_pkg::EGP_RST_ORDER;
			user_store   <= 4'h0;
			track_on     <= 1'b0;
			pack8        <= 1'b1;
			mark_density <= egp_pkg::EGP_RST_DENSITY;
		end else if (cmd_valid && cmd_ok) begin
			case (cmd_op)
				egp_pkg::EGP_CMD_SELECT_ED, egp_pkg::EGP_CMD_SELECT_PG: begin
					if (cmd_op == egp_pkg::EGP_CMD_SELECT_ED || track_on) begin	// R15 R16
						sel_kind  <= arg_kind;
						sel_order <= (arg_kind == egp_pkg::EGP_KIND_USER) ? 5'h00 : arg_n;	// R14
						if (arg_kind == egp_pkg::EGP_KIND_USER) begin
							user_store <= arg_n[3:0];	// R13
						end
					end
				end
				egp_pkg::EGP_CMD_TRACK: track_on <= cmd_arg[0];	// R16
				egp_pkg::EGP_CMD_PACKING: pack8 <= cmd_arg == egp_pkg::EGP_PACK8;	// R8
				egp_pkg::EGP_CMD_DENSITY: mark_density <= cmd_arg[7:0];	// R10
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Accumulation gate
	assign tick_end = tick_cnt_reg == 25'(CYCLES_PER_SEC - 1);
	assign hit = gate_on && !gate_cmd && (gate_by_errors ?
		(bit_error && (err_cnt_reg + 10'h001) == gate_err_period) :	// R3
		(tick_end && (sec_cnt_reg + 24'h00_0001) == gate_time_period));

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			gate_on       <= 1'b0;
			results_valid <= 1'b0;
			period_done   <= 1'b0;
			err_cnt_reg   <= '0;
			sec_cnt_reg   <= '0;
			tick_cnt_reg  <= '0;
		end else begin
			period_done <= hit;
			if (gate_cmd || hit) begin
				err_cnt_reg  <= '0;
				sec_cnt_reg  <= '0;
				tick_cnt_reg <= '0;
			end else if (gate_on) begin
				if (gate_by_errors && bit_error) begin
					err_cnt_reg <= err_cnt_reg + 10'h001;	// R3
				end
				tick_cnt_reg <= tick_end ? 25'h000_0000 : tick_cnt_reg + 25'h000_0001;
				if (tick_end) begin
					sec_cnt_reg <= sec_cnt_reg + 24'h00_0001;
				end
			end
			if (gate_cmd) begin
				gate_on <= cmd_arg[0];	// R5
			end else if (hit && gate_single) begin
				gate_on <= 1'b0;	// R7
			end
			if (period_wr) begin
				results_valid <= 1'b0;	// R4
			end
			if (hit) begin
				results_valid <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Pattern store engine
	assign bit_addr  = 8'(base_reg + pos_reg);
	assign unit_bit  = pack8 ? byte_reg[3'd7 - bit_idx_reg] : byte_reg[0];	// R9
	assign unit_good = pack8 || (byte_reg[7:1] == 7'h00);	// R8
	assign unit_last = !pack8 || (bit_idx_reg == 3'd7);
	assign pos_after = (remain_reg != 9'h000) ? pos_reg + 9'h001 : pos_reg;
	assign rd_bit    = pat_reg[bit_addr];
	assign rd_last   = !pack8 || rd_n_reg == 4'h7 || remain_reg == 9'h001;
	assign rd_done   = pack8 ? 8'({rd_acc_reg[6:0], rd_bit} << (3'd7 - rd_n_reg[2:0])) :
		{7'h00, rd_bit};

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			eng_reg            <= egp_pkg::EGP_ENG_IDLE;
			pat_reg            <= '0;
			pat_length         <= egp_pkg::EGP_RST_LEN;
			alt_mode           <= 1'b0;
			trigger_changeover <= 1'b0;
			pos_reg            <= '0;
			remain_reg         <= '0;
			base_reg           <= '0;
			bytes_left_reg     <= '0;
			byte_reg           <= '0;
			bit_idx_reg        <= '0;
			holding_reg        <= 1'b0;
			full_reg           <= 1'b0;
			dl_ready           <= 1'b0;
			dl_bad             <= 1'b0;
			rd_acc_reg         <= '0;
			rd_n_reg           <= '0;
			push_reg           <= 1'b0;
		end else begin
			dl_bad <= 1'b0;
			unique case (eng_reg)
				egp_pkg::EGP_ENG_IDLE: begin
					if (cmd_valid && cmd_ok) begin
						case (cmd_op)
							egp_pkg::EGP_CMD_MODE: begin
								alt_mode           <= cmd_arg[0];	// R21
								trigger_changeover <= cmd_arg[0];
								if (cmd_arg[0]) begin
									pat_length <= egp_pkg::EGP_HALF_BITS;	// R24
									pat_reg    <= '0;
								end
							end
							egp_pkg::EGP_CMD_LENGTH: pat_length <= cmd_arg[8:0];	// R22
							egp_pkg::EGP_CMD_WRITE_FULL, egp_pkg::EGP_CMD_WRITE_PART: begin
								full_reg       <= cmd_op == egp_pkg::EGP_CMD_WRITE_FULL;
								eng_reg        <= (cmd_bytes != 16'h0000) ?
									egp_pkg::EGP_ENG_WRITE : egp_pkg::EGP_ENG_IDLE;
								pos_reg        <= (cmd_op == egp_pkg::EGP_CMD_WRITE_FULL) ?
									9'h000 : {1'b0, cmd_start};	// R23
								remain_reg     <= (cmd_op == egp_pkg::EGP_CMD_WRITE_FULL) ?
									cap_of(alt_mode) : cmd_count;	// R20
								base_reg       <= half_base;	// R17
								bytes_left_reg <= cmd_bytes;	// R18
								dl_ready       <= cmd_bytes != 16'h0000;
							end
							egp_pkg::EGP_CMD_READ_PART: begin
								eng_reg    <= egp_pkg::EGP_ENG_READ;
								pos_reg    <= {1'b0, cmd_start};	// R23
								remain_reg <= cmd_count;	// R20
								base_reg   <= half_base;
								rd_n_reg   <= 4'h0;
							end
							default: ;
						endcase
					end
				end
				egp_pkg::EGP_ENG_WRITE: begin
					if (holding_reg) begin
						if (remain_reg != 9'h000) begin
							if (unit_good) begin
								pat_reg[bit_addr] <= unit_bit;	// R9
							end
							pos_reg    <= pos_reg + 9'h001;
							remain_reg <= remain_reg - 9'h001;
						end
						dl_bad      <= !unit_good;	// R8
						bit_idx_reg <= bit_idx_reg + 3'd1;
						if (unit_last) begin
							holding_reg <= 1'b0;
							bit_idx_reg <= 3'd0;
							if (bytes_left_reg == 16'h0000) begin
								eng_reg <= egp_pkg::EGP_ENG_IDLE;
								if (full_reg && pos_after != 9'h000) begin
									pat_length <= pos_after;	// R19 R25
								end
							end else begin
								dl_ready <= 1'b1;
							end
						end
					end else if (dl_valid && dl_ready) begin
						byte_reg       <= dl_byte;
						holding_reg    <= 1'b1;
						dl_ready       <= 1'b0;
						bytes_left_reg <= bytes_left_reg - 16'h0001;	// R18
					end
				end
				egp_pkg::EGP_ENG_READ: begin
					if (push_reg) begin
						if (buf_in_ready) begin
							push_reg <= 1'b0;
							rd_n_reg <= 4'h0;
							if (remain_reg == 9'h000) begin
								eng_reg <= egp_pkg::EGP_ENG_IDLE;
							end
						end
					end else begin
						rd_acc_reg <= rd_last ? rd_done : {rd_acc_reg[6:0], rd_bit};	// R20
						pos_reg    <= pos_reg + 9'h001;
						remain_reg <= remain_reg - 9'h001;
						rd_n_reg   <= rd_n_reg + 4'h1;
						push_reg   <= rd_last;
					end
				end
				default: eng_reg <= egp_pkg::EGP_ENG_IDLE;
			endcase
		end
	end

	egp_buffer #(
		.WIDTH (egp_pkg::EGP_BUF_WIDTH),
		.DEPTH (egp_pkg::EGP_BUF_DEPTH)
	) u_rd_buffer (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.in_valid  (push_reg),
		.in_data   (rd_acc_reg),
		.in_ready  (buf_in_ready),
		.out_valid (rd_valid),
		.out_data  (rd_byte),
		.out_ready (rd_ready)
	);

	// ==========================================================
	// Checks
	default clocking chk_cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_err_period_set: assert property (cmd_valid && cmd_op == egp_pkg::EGP_CMD_GATE_ERR && // R1
		cmd_arg == 24'h00_03E8 |=> cmd_ack && gate_err_period == 10'h3E8)
		else $error("error period 1000 not taken");
	a_time_zero_kept: assert property (cmd_valid && cmd_op == egp_pkg::EGP_CMD_GATE_TIME && // R26
		cmd_arg == 24'h00_0000 |=> cmd_err && $stable(gate_time_period))
		else $error("zero time period not refused");
	a_period_invalidates: assert property (period_wr && !gate_on |=> !results_valid) // R4
		else $error("period write left results valid");
	a_gate_state_follows: assert property (gate_cmd |=> gate_on == $past(cmd_arg[0])) // R5
		else $error("gate state not applied");
	a_single_close: assert property (hit && gate_single |=> !gate_on && period_done ##0 // R7
		results_valid) else $error("single period did not close");
	a_err_manner_only: assert property (gate_on && !gate_by_errors && bit_error && !tick_end && // R3
		!cmd_valid |=> gate_on && !period_done) else $error("error count used in time manner");
	a_zero_sub_refused: assert property (cmd_valid && cmd_op == egp_pkg::EGP_CMD_SELECT_ED && // R12
		arg_kind == egp_pkg::EGP_KIND_ZSUB |=> cmd_err && $stable(sel_kind))
		else $error("zero substitution accepted");
	a_user_short_type: assert property (sel_kind == egp_pkg::EGP_KIND_USER |-> // R14
		sel_order == 5'h00) else $error("user selection exposes index");
	a_uncoupled_pg: assert property (cmd_valid && cmd_op == egp_pkg::EGP_CMD_SELECT_PG && // R15
		!track_on |=> $stable(sel_kind) && $stable(sel_order)) else $error("uncoupled select");
	a_alt_entry: assert property (cmd_valid && cmd_ok && cmd_op == egp_pkg::EGP_CMD_MODE && // R24
		cmd_arg[0] |=> alt_mode && trigger_changeover && pat_length == 9'h080 && pat_reg == '0)
		else $error("alternate entry wrong");
	a_half_b_whole_pattern_mode: assert property (cmd_valid && cmd_half_b && !alt_mode && // R17
		cmd_op == egp_pkg::EGP_CMD_WRITE_FULL |=> cmd_err) else $error("half B in whole mode");
	a_msb_first_bit: assert property (eng_reg == egp_pkg::EGP_ENG_WRITE && holding_reg && // R9
		pack8 && bit_idx_reg == 3'd0 && remain_reg != 9'h000 |=>
		pat_reg[$past(bit_addr)] == $past(byte_reg[7])) else $error("packing order wrong");

	c_full_write_done: cover property (full_reg && eng_reg == egp_pkg::EGP_ENG_WRITE ##1
		eng_reg == egp_pkg::EGP_ENG_IDLE);
	c_period_done: cover property (period_done && results_valid);
	c_read_stalled: cover property (push_reg && !buf_in_ready);
	c_alt_half_b: cover property (alt_mode && cmd_valid && cmd_ok && cmd_half_b);

endmodule // egp_gate_pattern
